// [link_supervisor.sv]
`timescale 1ns/1ps
// Contract
// (R1) Startup only after all links held disabled for the full hold time.
// (R2) Startup resets control machines, blocks ports, nulls sub-processes, requests link.
// (R3) Startup: link up sends start-traffic, requests identity, starts identity timer.
// (R4) Startup: link release re-requests link and signals error, state kept.
// (R5) Identity match: stop timer, start PSTN link, unblock ISDN, in service.
// (R6) Identity mismatch: error, disable control link, start hold timer, force restart.
// (R7) Wait identity: release re-requests, stops timer, stops traffic, errors, to startup.
// (R8) Wait identity: control link reset indication causes nothing.
// (R9) PSTN null: if provisioned, request PSTN link and go activate.
// (R10) Activate: PSTN link up unblocks PSTN ports, enters PSTN in service.
// (R11) Activate: PSTN release re-requests and signals error, state kept.
// (R12) In service: release re-requests, starts first timer, errors, to released one.
// (R13) In service: control link reset indication ignored.
// (R14) Released one: link up stops first timer, back to in service.
// (R15) First timer expiry: stop traffic, block ISDN, start second timer.
// (R16) Released one: further release only re-requests the link.
// (R17) Second timer expiry: disable links, block PSTN, start forced restart timer.
// (R18) Released two: link up restarts traffic, unblocks ISDN, fires pending restart.
// (R19) Released two: release only re-requests the link.
// (R20) Links stay disabled while forced restart or hold timer runs.
// (R21) After hold time, enter deactivated state; startup allowed at once.
// (R22) Timers are tick-counted parameters, each started, stopped, expired alone; the forced restart and hold timers have stop tied off.
// (R23) Identity timer expiry raises a dedicated event output.
module link_supervisor
   import supervisor_pkg::*;
#(
   parameter logic [15:0] IDENT_LEN = supervisor_pkg::IDENT_TICKS,
   parameter logic [15:0] REL_ONE_LEN = supervisor_pkg::REL_ONE_TICKS,
   parameter logic [15:0] REL_TWO_LEN = supervisor_pkg::REL_TWO_TICKS,
   parameter logic [15:0] FORCE_LEN = supervisor_pkg::FORCE_TICKS,
   parameter logic [15:0] HOLD_LEN = supervisor_pkg::HOLD_TICKS,
   parameter logic [15:0] PRESCALE = supervisor_pkg::PRESCALE_DIV
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Management requests
   input wire logic startup_req,
   input wire logic pstn_provisioned,
   // Control link entity indications
   input wire logic ctrl_est_conf,
   input wire logic ctrl_est_ind,
   input wire logic ctrl_rel_ind,
   // PSTN link entity indications
   input wire logic pstn_est_conf,
   input wire logic pstn_est_ind,
   input wire logic pstn_rel_ind,
   // Identity check result
   input wire logic ident_valid,
   input wire logic ident_match,
   // Restart sub-process
   input wire logic pstn_restart_pending,
   // Control link entity requests
   output logic ctrl_est_req,
   output logic links_disabled,
   // PSTN link entity requests
   output logic pstn_est_req,
   // Control machines
   output logic ctrl_init,
   output logic start_traffic,
   output logic stop_traffic,
   output logic ident_req,
   // Port status machines
   output logic isdn_unblock,
   output logic isdn_block,
   output logic pstn_unblock,
   output logic pstn_block,
   output logic pstn_restart_req,
   // Management
   output logic error_ind,
   output logic ident_timeout,
   output logic deactivated,
   output logic [3:0] sys_state,
   output logic [1:0] pdl_state
);
   ////////////////////////////////////////////////////////////////
   // Timers

   logic tick;
   logic ti_start, ti_stop, ti_run, ti_exp;
   logic t1_start, t1_stop, t1_run, t1_exp;
   logic t2_start, t2_stop, t2_run, t2_exp;
   logic t8_start, t8_run, t8_exp;
   logic t9_start, t9_run, t9_exp;

   tick_prescaler #(.DIV(PRESCALE)) u_presc (.clk(clk), .resetn(resetn), .tick(tick));

   // Each timer counts independently on the shared tick [R22]
   sup_timer u_ident (.clk(clk), .resetn(resetn), .tick(tick), .start(ti_start), .stop(ti_stop),
      .length(IDENT_LEN), .running(ti_run), .expired(ti_exp));
   sup_timer u_rel1 (.clk(clk), .resetn(resetn), .tick(tick), .start(t1_start), .stop(t1_stop),
      .length(REL_ONE_LEN), .running(t1_run), .expired(t1_exp));
   sup_timer u_rel2 (.clk(clk), .resetn(resetn), .tick(tick), .start(t2_start), .stop(t2_stop),
      .length(REL_TWO_LEN), .running(t2_run), .expired(t2_exp));
   sup_timer u_force (.clk(clk), .resetn(resetn), .tick(tick), .start(t8_start), .stop(1'b0),
      .length(FORCE_LEN), .running(t8_run), .expired(t8_exp));
   sup_timer u_hold (.clk(clk), .resetn(resetn), .tick(tick), .start(t9_start), .stop(1'b0),
      .length(HOLD_LEN), .running(t9_run), .expired(t9_exp));

   ////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      sys_state_t sys;
      pdl_state_t pdl;
      logic pdl_go;
      logic ctrl_est_req;
      logic links_disabled;
      logic pstn_est_req;
      logic ctrl_init;
      logic start_traffic;
      logic stop_traffic;
      logic ident_req;
      logic isdn_unblock;
      logic isdn_block;
      logic pstn_unblock;
      logic pstn_block;
      logic pstn_restart_req;
      logic error_ind;
      logic ident_timeout;
      logic boot;
      logic deactivated;
   } sup_t;
   sup_t s_q, s_d;

   logic ctrl_up;
   logic pstn_up;
   assign ctrl_up = ctrl_est_conf | ctrl_est_ind;
   assign pstn_up = pstn_est_conf | pstn_est_ind;

   // Main sequencing; output strobes are cleared each cycle and last one cycle
   always_comb begin
      s_d = s_q;
      s_d.ctrl_est_req = 1'b0;
      s_d.pstn_est_req = 1'b0;
      s_d.ctrl_init = 1'b0;
      s_d.start_traffic = 1'b0;
      s_d.stop_traffic = 1'b0;
      s_d.ident_req = 1'b0;
      s_d.isdn_unblock = 1'b0;
      s_d.isdn_block = 1'b0;
      s_d.pstn_unblock = 1'b0;
      s_d.pstn_block = 1'b0;
      s_d.pstn_restart_req = 1'b0;
      s_d.error_ind = 1'b0;
      s_d.ident_timeout = ti_exp; // [R23]
      s_d.pdl_go = 1'b0;
      s_d.boot = 1'b0;
      ti_start = 1'b0;
      ti_stop = 1'b0;
      t1_start = 1'b0;
      t1_stop = 1'b0;
      t2_start = 1'b0;
      t2_stop = 1'b0;
      t8_start = 1'b0;
      t9_start = 1'b0;
      unique case (s_q.sys)
         SYS_DEACTIVE: begin
            // Reached only after the hold time, so startup may go now [R1]
            if (startup_req) begin
               s_d.links_disabled = 1'b0;
               s_d.ctrl_init = 1'b1; // [R2]
               s_d.isdn_block = 1'b1;
               s_d.pstn_block = 1'b1;
               s_d.pdl = PDL_NULL;
               s_d.ctrl_est_req = 1'b1;
               s_d.sys = SYS_STARTUP;
            end
         end
         SYS_STARTUP: begin
            if (ctrl_up) begin
               s_d.start_traffic = 1'b1; // [R3]
               s_d.ident_req = 1'b1;
               ti_start = 1'b1;
               s_d.sys = SYS_WAIT_IDENT;
            end else if (ctrl_rel_ind) begin
               s_d.ctrl_est_req = 1'b1; // [R4]
               s_d.error_ind = 1'b1;
            end
         end
         SYS_WAIT_IDENT: begin
            // A reset indication alone leaves this state untouched [R8]
            if (ctrl_rel_ind) begin
               s_d.ctrl_est_req = 1'b1; // [R7]
               ti_stop = 1'b1;
               s_d.stop_traffic = 1'b1;
               s_d.error_ind = 1'b1;
               s_d.sys = SYS_STARTUP;
            end else if (ident_valid && ident_match) begin
               ti_stop = 1'b1; // [R5]
               s_d.pdl_go = 1'b1;
               s_d.isdn_unblock = 1'b1;
               s_d.sys = SYS_IN_SERVICE;
            end else if (ident_valid) begin
               s_d.error_ind = 1'b1; // [R6]
               s_d.links_disabled = 1'b1;
               ti_stop = 1'b1;
               t9_start = 1'b1;
               s_d.sys = SYS_FORCE_RESTART;
            end
         end
         SYS_IN_SERVICE: begin
            // Reset indications are ignored here [R13]
            if (ctrl_rel_ind) begin
               s_d.ctrl_est_req = 1'b1; // [R12]
               t1_start = 1'b1;
               s_d.error_ind = 1'b1;
               s_d.sys = SYS_REL_ONE;
            end
         end
         SYS_REL_ONE: begin
            if (ctrl_up) begin
               t1_stop = 1'b1; // [R14]
               s_d.sys = SYS_IN_SERVICE;
            end else if (t1_exp) begin
               s_d.stop_traffic = 1'b1; // [R15]
               s_d.isdn_block = 1'b1;
               t2_start = 1'b1;
               s_d.sys = SYS_REL_TWO;
            end else if (ctrl_rel_ind) begin
               s_d.ctrl_est_req = 1'b1; // [R16]
            end
         end
         SYS_REL_TWO: begin
            // Re-establishment beats a same-cycle expiry: service is restored
            if (ctrl_up) begin
               t2_stop = 1'b1; // [R18]
               s_d.start_traffic = 1'b1;
               s_d.isdn_unblock = 1'b1;
               s_d.pstn_restart_req = pstn_restart_pending;
               s_d.sys = SYS_IN_SERVICE;
            end else if (t2_exp) begin
               s_d.links_disabled = 1'b1; // [R17]
               s_d.pstn_block = 1'b1;
               t8_start = 1'b1;
               s_d.sys = SYS_FORCE_RESTART;
            end else if (ctrl_rel_ind) begin
               s_d.ctrl_est_req = 1'b1; // [R19]
            end
         end
         SYS_FORCE_RESTART: begin
            // Links kept disabled; forced restart time chains into hold time [R20]
            s_d.links_disabled = 1'b1;
            if (t8_exp) begin
               t9_start = 1'b1;
            end else if (t9_exp) begin
               s_d.sys = SYS_DEACTIVE; // [R21]
            end
         end
         default: begin
            s_d.sys = SYS_FORCE_RESTART;
            s_d.links_disabled = 1'b1;
            t9_start = 1'b1;
         end
      endcase

      // PSTN link sub-process
      unique case (s_q.pdl)
         PDL_NULL: begin
            if (s_q.pdl_go && pstn_provisioned) begin
               s_d.pstn_est_req = 1'b1; // [R9]
               s_d.pdl = PDL_ACTIVATE;
            end
         end
         PDL_ACTIVATE: begin
            if (pstn_up) begin
               s_d.pstn_unblock = 1'b1; // [R10]
               s_d.pdl = PDL_IN_SERVICE;
            end else if (pstn_rel_ind) begin
               s_d.pstn_est_req = 1'b1; // [R11]
               s_d.error_ind = 1'b1;
            end
         end
         PDL_IN_SERVICE: begin
            s_d.pdl = PDL_IN_SERVICE;
         end
         default: begin
            s_d.pdl = PDL_NULL;
         end
      endcase
      // A startup pass clears the sub-process
      if (s_q.sys == SYS_DEACTIVE && startup_req) begin
         s_d.pdl = PDL_NULL;
      end
      // Hold timer is kicked once after reset, else the restart state never ends [R1]
      if (s_q.boot) begin
         t9_start = 1'b1;
      end
      s_d.deactivated = (s_d.sys == SYS_DEACTIVE); // [R21]
   end

   // Reset lands in the restart hold so the peer also sees a full outage
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.sys <= SYS_FORCE_RESTART;
         s_q.links_disabled <= 1'b1;
         s_q.boot <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Outputs

   assign ctrl_est_req = s_q.ctrl_est_req;
   assign links_disabled = s_q.links_disabled;
   assign pstn_est_req = s_q.pstn_est_req;
   assign ctrl_init = s_q.ctrl_init;
   assign start_traffic = s_q.start_traffic;
   assign stop_traffic = s_q.stop_traffic;
   assign ident_req = s_q.ident_req;
   assign isdn_unblock = s_q.isdn_unblock;
   assign isdn_block = s_q.isdn_block;
   assign pstn_unblock = s_q.pstn_unblock;
   assign pstn_block = s_q.pstn_block;
   assign pstn_restart_req = s_q.pstn_restart_req;
   assign error_ind = s_q.error_ind;
   assign ident_timeout = s_q.ident_timeout;
   assign deactivated = s_q.deactivated;
   assign sys_state = s_q.sys;
   assign pdl_state = s_q.pdl;

   ////////////////////////////////////////////////////////////////
   // Assertions

   logic hold_kick;
   assign hold_kick = s_q.boot & resetn;

   sequence s_rel_in_service;
      s_q.sys == SYS_IN_SERVICE && ctrl_rel_ind;
   endsequence

   sequence s_rel_one_entry;
      s_q.sys == SYS_REL_ONE && ctrl_est_req && error_ind && t1_run;
   endsequence

   a_in_service_release: assert property (@(posedge clk) disable iff (!resetn) // [R12]
      s_rel_in_service |=> s_rel_one_entry) else $error("release in service mishandled");
   a_startup_link_up: assert property (@(posedge clk) disable iff (!resetn) // [R3]
      (s_q.sys == SYS_STARTUP && ctrl_up) |=> (s_q.sys == SYS_WAIT_IDENT && start_traffic && ident_req && ti_run))
      else $error("startup link up mishandled");
   a_startup_release: assert property (@(posedge clk) disable iff (!resetn) // [R4]
      (s_q.sys == SYS_STARTUP && !ctrl_up && ctrl_rel_ind) |=> (s_q.sys == SYS_STARTUP && ctrl_est_req && error_ind))
      else $error("startup release mishandled");
   a_ident_match: assert property (@(posedge clk) disable iff (!resetn) // [R5]
      (s_q.sys == SYS_WAIT_IDENT && !ctrl_rel_ind && ident_valid && ident_match)
      |=> (s_q.sys == SYS_IN_SERVICE && isdn_unblock && !ti_run)) else $error("identity match mishandled");
   a_ident_fail: assert property (@(posedge clk) disable iff (!resetn) // [R6]
      (s_q.sys == SYS_WAIT_IDENT && !ctrl_rel_ind && ident_valid && !ident_match)
      |=> (s_q.sys == SYS_FORCE_RESTART && links_disabled && error_ind && t9_run)) else $error("identity fail");
   a_wait_release: assert property (@(posedge clk) disable iff (!resetn) // [R7]
      (s_q.sys == SYS_WAIT_IDENT && ctrl_rel_ind) |=> (s_q.sys == SYS_STARTUP && stop_traffic && !ti_run))
      else $error("wait release mishandled");
   a_rel_one_expiry: assert property (@(posedge clk) disable iff (!resetn) // [R15]
      (s_q.sys == SYS_REL_ONE && !ctrl_up && t1_exp) |=> (s_q.sys == SYS_REL_TWO && isdn_block && stop_traffic))
      else $error("first expiry mishandled");
   a_rel_two_expiry: assert property (@(posedge clk) disable iff (!resetn) // [R17]
      (s_q.sys == SYS_REL_TWO && !ctrl_up && t2_exp) |=> (links_disabled && pstn_block && t8_run))
      else $error("second expiry mishandled");
   a_force_links_off: assert property (@(posedge clk) disable iff (!resetn) // [R20]
      (t8_run || t9_run) |-> links_disabled) else $error("links enabled during restart hold");
   a_ident_event: assert property (@(posedge clk) disable iff (!resetn) // [R23]
      ti_exp |=> ident_timeout) else $error("identity timeout not raised");
   a_hold_starts: assert property (@(posedge clk) disable iff (!resetn) // [R1]
      hold_kick |=> t9_run) else $error("hold timer not started after reset");
endmodule : link_supervisor

// [supervisor_pkg.sv]
package supervisor_pkg;
   // Default timer lengths in prescaled ticks, and the clock divisor that makes a tick
   localparam int TMR_W = 16;
   localparam logic [15:0] IDENT_TICKS = 16'h0064;
   localparam logic [15:0] REL_ONE_TICKS = 16'h0032;
   localparam logic [15:0] REL_TWO_TICKS = 16'h0064;
   localparam logic [15:0] FORCE_TICKS = 16'h0064;
   localparam logic [15:0] HOLD_TICKS = 16'h0064;
   localparam logic [15:0] PRESCALE_DIV = 16'h00C8;
   // Reset values
   localparam logic [15:0] TMR_RESET = 16'h0000;

   typedef enum logic [3:0] {
      SYS_DEACTIVE = 4'h0,
      SYS_STARTUP = 4'h1,
      SYS_WAIT_IDENT = 4'h2,
      SYS_IN_SERVICE = 4'h3,
      SYS_REL_ONE = 4'h4,
      SYS_REL_TWO = 4'h5,
      SYS_FORCE_RESTART = 4'h6
   } sys_state_t;

   typedef enum logic [1:0] {
      PDL_NULL = 2'h0,
      PDL_ACTIVATE = 2'h1,
      PDL_IN_SERVICE = 2'h2
   } pdl_state_t;
endpackage : supervisor_pkg

// [tick_prescaler.sv]
`timescale 1ns/1ps
module tick_prescaler #(
   parameter logic [15:0] DIV = 16'h00C8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Time base
   output logic tick
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } presc_t;
   presc_t s_q, s_d;

   // Divide clock into a slow tick so long timers stay narrow
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt >= DIV - 16'h0001) begin
         s_d.cnt = 16'h0000;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;
endmodule : tick_prescaler

// [sup_timer.sv]
`timescale 1ns/1ps
module sup_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Control
   input wire logic tick,
   input wire logic start,
   input wire logic stop,
   input wire logic [15:0] length,
   // Status
   output logic running,
   output logic expired
);
   import supervisor_pkg::*;
   typedef struct packed {
      logic [15:0] cnt;
      logic run;
      logic exp;
   } tmr_t;
   tmr_t s_q, s_d;

   // Start wins over stop; expiry is a one-cycle pulse
   always_comb begin
      s_d = s_q;
      s_d.exp = 1'b0;
      if (start) begin
         s_d.run = 1'b1;
         s_d.cnt = (length == 16'h0000) ? 16'h0001 : length;
      end else if (stop) begin
         s_d.run = 1'b0;
      end else if (s_q.run && tick) begin
         if (s_q.cnt <= 16'h0001) begin
            s_d.run = 1'b0;
            s_d.exp = 1'b1;
            s_d.cnt = TMR_RESET;
         end else begin
            s_d.cnt = s_q.cnt - 16'h0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign running = s_q.run;
   assign expired = s_q.exp;
endmodule : sup_timer

// [link_entity_model.sv]
`timescale 1ns/1ps
// Stand-in for the control and PSTN link entities: confirms establish requests
module link_entity_model (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Behaviour, delay in cycles and at least one
   input wire logic ack_en,
   input wire logic [3:0] delay,
   // Requests from the supervisor
   input wire logic ctrl_est_req,
   input wire logic pstn_est_req,
   input wire logic links_disabled,
   // Confirmations back
   output logic ctrl_est_conf,
   output logic pstn_est_conf
);
   int ctrl_cnt = 0;
   int pstn_cnt = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs change on the falling edge, like every other bench driver
   initial begin
      ctrl_est_conf = 1'b0;
      pstn_est_conf = 1'b0;
   end

   // A disabled link never comes up, so pending confirmations are dropped
   always @(negedge clk) begin
      ctrl_est_conf <= 1'b0;
      pstn_est_conf <= 1'b0;
      if (!resetn || !ack_en || links_disabled) begin
         ctrl_cnt = 0;
         pstn_cnt = 0;
      end else begin
         if (ctrl_est_req) begin
            ctrl_cnt = delay;
         end else if (ctrl_cnt > 0) begin
            ctrl_cnt--;
            ctrl_est_conf <= (ctrl_cnt == 0);
         end
         if (pstn_est_req) begin
            pstn_cnt = delay;
         end else if (pstn_cnt > 0) begin
            pstn_cnt--;
            pstn_est_conf <= (pstn_cnt == 0);
         end
      end
   end
endmodule : link_entity_model

// [testbench.sv]
`timescale 1ns/1ps
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin fail_count++; \
   $display("[ERR] %0t act=%0h exp=%0h", $time, (act), (exp)); end end
module testbench;
   import supervisor_pkg::*;
   // Short timers keep the run brief; one tick is two clocks
   localparam logic [15:0] PS = 16'h0002;
   localparam logic [15:0] IL = 16'h0005;
   localparam logic [15:0] R1L = 16'h0003;
   localparam logic [15:0] R2L = 16'h0006;
   localparam logic [15:0] FL = 16'h0003;
   localparam logic [15:0] HL = 16'h0003;
   // Pulse vector bits
   localparam logic [12:0] P_CER = 13'h1000, P_PER = 13'h0800, P_INIT = 13'h0400, P_ST = 13'h0200;
   localparam logic [12:0] P_SP = 13'h0100, P_IR = 13'h0080, P_IU = 13'h0040, P_IB = 13'h0020;
   localparam logic [12:0] P_PU = 13'h0010, P_PB = 13'h0008, P_RR = 13'h0004, P_ERR = 13'h0002;
   localparam logic [12:0] P_TO = 13'h0001;
   // Bench-driven inputs; ev bits: start, c_conf, c_ind, c_rel, p_conf, p_ind, p_rel, ident
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] ev = 8'h00;
   logic ident_match = 1'b0;
   logic prov = 1'b1;
   logic restart_pend = 1'b0;
   logic ack_en = 1'b0;
   logic [3:0] delay = 4'h4;
   logic m_ctrl_conf, m_pstn_conf;
   // Design outputs
   logic ctrl_est_req, links_disabled, pstn_est_req, ctrl_init, start_traffic, stop_traffic, ident_req;
   logic isdn_unblock, isdn_block, pstn_unblock, pstn_block, pstn_restart_req, error_ind, ident_timeout;
   logic deactivated;
   logic [3:0] sys_state;
   logic [1:0] pdl_state;
   logic [12:0] pulses;
   int fail_count = 0;
   int total_checks = 0;

   ////////////////////////////////////////////////////////////////////////////////
   always #2.5 clk = ~clk;

   assign pulses = {ctrl_est_req, pstn_est_req, ctrl_init, start_traffic, stop_traffic, ident_req,
      isdn_unblock, isdn_block, pstn_unblock, pstn_block, pstn_restart_req, error_ind, ident_timeout};

   link_supervisor #(.IDENT_LEN(IL), .REL_ONE_LEN(R1L), .REL_TWO_LEN(R2L), .FORCE_LEN(FL), .HOLD_LEN(HL),
      .PRESCALE(PS)) i_dut (.clk(clk), .resetn(resetn), .startup_req(ev[0]), .pstn_provisioned(prov),
      .ctrl_est_conf(ev[1] | m_ctrl_conf), .ctrl_est_ind(ev[2]), .ctrl_rel_ind(ev[3]),
      .pstn_est_conf(ev[4] | m_pstn_conf), .pstn_est_ind(ev[5]), .pstn_rel_ind(ev[6]),
      .ident_valid(ev[7]), .ident_match(ident_match), .pstn_restart_pending(restart_pend),
      .ctrl_est_req(ctrl_est_req), .links_disabled(links_disabled), .pstn_est_req(pstn_est_req),
      .ctrl_init(ctrl_init), .start_traffic(start_traffic), .stop_traffic(stop_traffic), .ident_req(ident_req),
      .isdn_unblock(isdn_unblock), .isdn_block(isdn_block), .pstn_unblock(pstn_unblock), .pstn_block(pstn_block),
      .pstn_restart_req(pstn_restart_req), .error_ind(error_ind), .ident_timeout(ident_timeout),
      .deactivated(deactivated), .sys_state(sys_state), .pdl_state(pdl_state));

   link_entity_model i_link (.clk(clk), .resetn(resetn), .ack_en(ack_en), .delay(delay),
      .ctrl_est_req(ctrl_est_req), .pstn_est_req(pstn_est_req), .links_disabled(links_disabled),
      .ctrl_est_conf(m_ctrl_conf), .pstn_est_conf(m_pstn_conf));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      if (fail_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   // One-cycle event; returns where the registered answer stands
   task automatic fire(input logic [7:0] e);
      @(negedge clk);
      ev = e;
      @(negedge clk);
      ev = 8'h00;
   endtask : fire

   // Bounded wait for a state; a spent bound ends the run
   task automatic wait_state(input logic [3:0] s, input int bound, output int n);
      n = 0;
      while (sys_state !== s) begin
         if (n >= bound) begin
            fail_count++;
            tally_and_finish();
         end
         if (s === SYS_DEACTIVE) `CHK(links_disabled, 1'b1)
         @(negedge clk);
         n++;
      end
   endtask : wait_state

   task automatic bring_up;
      fire(8'h01);
      `CHK({sys_state, links_disabled, pulses}, {SYS_STARTUP, 1'b0, P_CER | P_INIT | P_IB | P_PB})
      fire(8'h02);
      `CHK({sys_state, pulses}, {SYS_WAIT_IDENT, P_ST | P_IR})
   endtask : bring_up

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_hold;
      int n;
      fire(8'h01);
      `CHK({sys_state, links_disabled, pulses}, {SYS_FORCE_RESTART, 1'b1, 13'h0000})
      wait_state(SYS_DEACTIVE, 200, n);
      `CHK(n + 2 >= (HL - 1) * PS, 1'b1)
      `CHK({deactivated, pulses}, {1'b1, 13'h0000})
   endtask : t_reset_hold

   task automatic t_startup;
      fire(8'h01);
      `CHK({sys_state, pulses}, {SYS_STARTUP, P_CER | P_INIT | P_IB | P_PB})
      fire(8'h08);
      `CHK({sys_state, pulses}, {SYS_STARTUP, P_CER | P_ERR})
      fire(8'h04);
      `CHK({sys_state, pulses}, {SYS_WAIT_IDENT, P_ST | P_IR})
      fire(8'h04);
      `CHK({sys_state, pulses}, {SYS_WAIT_IDENT, 13'h0000})
      fire(8'h08);
      `CHK({sys_state, pulses}, {SYS_STARTUP, P_CER | P_SP | P_ERR})
      fire(8'h02);
      ident_match = 1'b1;
      fire(8'h80);
      `CHK({sys_state, pulses}, {SYS_IN_SERVICE, P_IU})
      @(negedge clk);
      `CHK({pdl_state, pulses}, {PDL_ACTIVATE, P_PER})
      fire(8'h40);
      `CHK({pdl_state, pulses}, {PDL_ACTIVATE, P_PER | P_ERR})
      fire(8'h10);
      `CHK({pdl_state, pulses}, {PDL_IN_SERVICE, P_PU})
      fire(8'h04);
      `CHK({sys_state, pulses}, {SYS_IN_SERVICE, 13'h0000})
   endtask : t_startup

   task automatic t_release_recover;
      int n;
      fire(8'h08);
      `CHK({sys_state, pulses}, {SYS_REL_ONE, P_CER | P_ERR})
      fire(8'h08);
      `CHK({sys_state, pulses}, {SYS_REL_ONE, P_CER})
      fire(8'h02);
      `CHK({sys_state, pulses}, {SYS_IN_SERVICE, 13'h0000})
      fire(8'h08);
      wait_state(SYS_REL_TWO, 40, n);
      `CHK({pulses, n + 2 >= (R1L - 1) * PS}, {P_SP | P_IB, 1'b1})
      ack_en = 1'b1;
      restart_pend = 1'b1;
      fire(8'h08);
      `CHK({sys_state, pulses}, {SYS_REL_TWO, P_CER})
      wait_state(SYS_IN_SERVICE, 20, n);
      `CHK(pulses, P_ST | P_IU | P_RR)
      ack_en = 1'b0;
      restart_pend = 1'b0;
   endtask : t_release_recover

   task automatic t_force_restart;
      int n;
      fire(8'h08);
      `CHK({sys_state, pulses}, {SYS_REL_ONE, P_CER | P_ERR})
      wait_state(SYS_REL_TWO, 40, n);
      wait_state(SYS_FORCE_RESTART, 60, n);
      `CHK({links_disabled, pulses, n + 2 >= (R2L - 1) * PS}, {1'b1, P_PB, 1'b1})
      wait_state(SYS_DEACTIVE, 200, n);
      `CHK({deactivated, n + 2 >= (FL + HL - 2) * PS}, 2'b11)
   endtask : t_force_restart

   task automatic t_ident_mismatch;
      int n;
      bring_up();
      ident_match = 1'b0;
      fire(8'h80);
      `CHK({sys_state, links_disabled, pulses}, {SYS_FORCE_RESTART, 1'b1, P_ERR})
      wait_state(SYS_DEACTIVE, 200, n);
      `CHK(n + 2 >= (HL - 1) * PS, 1'b1)
   endtask : t_ident_mismatch

   task automatic t_ident_timeout;
      int n;
      bring_up();
      n = 0;
      while (ident_timeout !== 1'b1) begin
         if (n >= 40) begin
            fail_count++;
            tally_and_finish();
         end
         @(negedge clk);
         n++;
      end
      `CHK({sys_state, pulses, n + 2 >= (IL - 1) * PS}, {SYS_WAIT_IDENT, P_TO, 1'b1})
      prov = 1'b0;
      ident_match = 1'b1;
      fire(8'h80);
      `CHK({sys_state, pulses}, {SYS_IN_SERVICE, P_IU})
      @(negedge clk);
      `CHK({pdl_state, pulses}, {PDL_NULL, 13'h0000})
   endtask : t_ident_timeout

   ////////////////////////////////////////////////////////////////////////////////
   // Reset for four cycles, then the scenarios in an order that chains their states
   initial begin
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      t_reset_hold();
      t_startup();
      t_release_recover();
      t_force_restart();
      t_ident_mismatch();
      t_ident_timeout();
      tally_and_finish();
   end
endmodule : testbench
